// *** verilog/cfb_pkg.sv ***
// Purpose: Shared constants and types of the clock fanout buffer control
//          logic and of the bus host that programs it.
// Assumes: One 25 MHz system clock in each end.
// Notes:   Functional notes below.
package cfb_pkg;
	localparam int NUM_OUT     = 7;
	localparam int NUM_REG     = 8;
	localparam int CLK_HZ      = 25_000_000;
	localparam int SMB_HZ_MAX  = 400_000;
	localparam int SCL_QTR_CYC = (CLK_HZ + 4 * SMB_HZ_MAX - 1) /
	                             (4 * SMB_HZ_MAX);
	localparam int TDRV_US     = 300;
	localparam int TDRV_CYC    = TDRV_US * (CLK_HZ / 1_000_000);
	localparam int TSTAB_MS    = 1;
	localparam int TSTAB_CYC   = TSTAB_MS * (CLK_HZ / 1_000);
	localparam int WAKE_MAX    = (TDRV_CYC < TSTAB_CYC) ? TDRV_CYC : TSTAB_CYC;
	localparam logic [2:0] WAKE_EDGES = 3'h4;
	localparam logic [5:0] REF_TO_CYC = 6'h20;

	// Bit positions in the synchroniser vector of the device
	localparam int SY_W   = 13;
	localparam int SY_SCL = 12;
	localparam int SY_SDA = 11;
	localparam int SY_REF = 10;
	localparam int SY_PWR = 9;
	localparam int SY_SEL = 7;

	localparam logic [1:0] SEL_LOW = 2'h0;
	localparam logic [1:0] SEL_MID = 2'h1;
	localparam logic [6:0] ADDR_LOW  = 7'h6B;
	localparam logic [6:0] ADDR_MID  = 7'h6C;
	localparam logic [6:0] ADDR_HIGH = 7'h6D;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	localparam logic [7:0] REG_RST [NUM_REG] = '{8'hFD, 8'h62, 8'hFD, 8'h45,
	                                             8'hFF, 8'h00, 8'h00, 8'h08};
	localparam logic [NUM_REG-1:0] REG_WR_MASK = 8'h8F;
	localparam int OE_BYTE [NUM_OUT] = '{0, 0, 0, 0, 0, 0, 1};
	localparam int OE_BIT  [NUM_OUT] = '{0, 2, 3, 4, 6, 7, 5};

	typedef enum logic [3:0] {
		PH_ADDR  = 4'h1,
		PH_INDEX = 4'h2,
		PH_COUNT = 4'h4,
		PH_DATA  = 4'h8
	} cfb_phase_t;

	typedef enum logic [3:0] {
		D_IDLE = 4'h1,
		D_RX   = 4'h2,
		D_ACK  = 4'h4,
		D_IGN  = 4'h8
	} cfb_dstate_t;

	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_START = 5'h02,
		H_BIT   = 5'h04,
		H_LOAD  = 5'h08,
		H_STOP  = 5'h10
	} cfb_hstate_t;
endpackage : cfb_pkg

// *** verilog/cfb_smb_if.sv ***
// Purpose: Two-wire management bus between host and fanout device.
// Assumes: Both wires open drain with pull-up; low wins.
// Notes:   Wire levels are resolved here from the drive enables.
`timescale 1ns/100ps
interface cfb_smb_if;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;

	assign scl = ~(h_scl_oe & ~h_scl_o);
	assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

	modport dev  (input scl, sda, output d_sda_o, d_sda_oe);
	modport host (input scl, sda, output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe);
endinterface : cfb_smb_if

// *** verilog/cfb_dev.sv ***
// Purpose: Fanout buffer control: bus target for indexed block write and
//          output gating by enable pins and power-good.
// Assumes: Reference clock slower than a quarter of clk_i.
// Notes:   Written bytes leave through a two-entry buffer.
`timescale 1ns/100ps
module cfb_dev
	import cfb_pkg::*;
#(
	parameter int WAKE_MAX_CYC = WAKE_MAX
) (
	input  wire logic               clk_i,
	input  wire logic               nrst_i,
	cfb_smb_if.dev                  smb,
	input  wire logic               diff_ref_clock_input_i,
	input  wire logic               power_good_powerdown_n_i,
	input  wire logic [NUM_OUT-1:0] oe_n_i,
	input  wire logic [1:0]         bus_addr_select_pin_i,
	input  wire logic               wr_ready_i,
	output logic [NUM_OUT-1:0]      diff_clock_output_o,
	output logic                    active_o,
	output logic                    wr_valid_o,
	output logic [7:0]              wr_index_o,
	output logic [7:0]              wr_data_o
);
	typedef struct packed {
		logic [SY_W-1:0]              s1;
		logic [SY_W-1:0]              s2;
		logic [SY_W-1:0]              pv;
		logic                         started;
		logic                         pd;
		logic [6:0]                   addr;
		logic [14:0]                  wake;
		logic [2:0]                   wedges;
		logic                         awake;
		logic [5:0]                   refto;
		logic [NUM_OUT-1:0]           gate;
		logic [NUM_OUT-1:0]           dclk;
		cfb_dstate_t                  state;
		cfb_phase_t                   phase;
		logic [3:0]                   bits;
		logic [7:0]                   sh;
		logic [7:0]                   idx;
		logic [7:0]                   left;
		logic                         sda_oe;
		logic [1:0]                   fv;
		logic [15:0]                  fe0;
		logic [15:0]                  fe1;
		logic [NUM_REG-1:0][7:0]      regs;
	} cfb_dev_st_t;

	cfb_dev_st_t st_ff;
	cfb_dev_st_t nxt_st;

	logic scl_rise;
	logic scl_fall;
	logic sda_rise;
	logic sda_fall;
	logic ref_rise;
	logic ref_edge;
	logic alive;
	logic op;
	logic ack;
	logic push;
	logic pop;
	logic room;

	assign scl_rise = st_ff.s2[SY_SCL] & ~st_ff.pv[SY_SCL];
	assign scl_fall = ~st_ff.s2[SY_SCL] & st_ff.pv[SY_SCL];
	assign sda_rise = st_ff.s2[SY_SDA] & ~st_ff.pv[SY_SDA];
	assign sda_fall = ~st_ff.s2[SY_SDA] & st_ff.pv[SY_SDA];
	assign ref_rise = st_ff.s2[SY_REF] & ~st_ff.pv[SY_REF];
	assign ref_edge = st_ff.s2[SY_REF] ^ st_ff.pv[SY_REF];
	assign alive    = (st_ff.refto != REF_TO_CYC);
	assign op       = st_ff.started & ~st_ff.pd & alive;
	assign pop      = st_ff.fv[0] & wr_ready_i;
	// A full buffer refuses the byte rather than overwrite it
	assign room     = ~st_ff.fv[1];

	always_comb begin
		nxt_st = st_ff;
		ack    = 1'b0;
		push   = 1'b0;
		nxt_st.s1 = {smb.scl, smb.sda, diff_ref_clock_input_i,
		             power_good_powerdown_n_i, bus_addr_select_pin_i, oe_n_i};
		nxt_st.s2 = st_ff.s1;
		nxt_st.pv = st_ff.s2;

		// Reference clock watchdog
		if (ref_edge) begin
			nxt_st.refto = 6'h00;
		end else if (alive) begin
			nxt_st.refto = st_ff.refto + 6'h01;
		end

		// Power-good handling
		if (!st_ff.s2[SY_PWR]) begin
			nxt_st.pd     = 1'b1;
			nxt_st.awake  = 1'b0;
			nxt_st.wake   = 15'h0000;
			nxt_st.wedges = 3'h0;
		end else begin
			nxt_st.pd = 1'b0;
			if (!st_ff.started) begin
				nxt_st.started = 1'b1;
				case (st_ff.s2[SY_SEL +: 2])
					SEL_LOW: nxt_st.addr = ADDR_LOW;
					SEL_MID: nxt_st.addr = ADDR_MID;
					default: nxt_st.addr = ADDR_HIGH;
				endcase
			end
			if (!st_ff.awake) begin
				nxt_st.wake = st_ff.wake + 15'h0001;
				if (ref_rise && st_ff.wedges != WAKE_EDGES) begin
					nxt_st.wedges = st_ff.wedges + 3'h1;
				end
				// Deadline keeps the wake bounded even on a slow reference
				if (st_ff.wedges == WAKE_EDGES ||
				    st_ff.wake == 15'(WAKE_MAX_CYC - 1)) begin
					nxt_st.awake = 1'b1;
				end
			end
		end

		// Gates change on a reference rising edge so no runt appears, except that they clear at once while not awake
		for (int i = 0; i < NUM_OUT; i++) begin
			if (!st_ff.awake) begin
				nxt_st.gate[i] = 1'b0;
			end else if (ref_rise) begin
				nxt_st.gate[i] = ~st_ff.s2[i] &
				                 st_ff.regs[OE_BYTE[i]][OE_BIT[i]];
			end
			nxt_st.dclk[i] = nxt_st.gate[i] & st_ff.s2[SY_REF];
		end

		// Bus target
		if (!op) begin
			nxt_st.state  = D_IDLE;
			nxt_st.sda_oe = 1'b0;
		end else if (st_ff.s2[SY_SCL] && sda_fall) begin
			nxt_st.state  = D_RX;
			nxt_st.phase  = PH_ADDR;
			nxt_st.bits   = 4'h0;
			nxt_st.sda_oe = 1'b0;
		end else if (st_ff.s2[SY_SCL] && sda_rise) begin
			nxt_st.state  = D_IDLE;
			nxt_st.sda_oe = 1'b0;
		end else begin
			case (st_ff.state)
				D_RX: begin
					if (scl_rise && st_ff.bits != BYTE_BITS) begin
						nxt_st.sh   = {st_ff.sh[6:0], st_ff.s2[SY_SDA]};
						nxt_st.bits = st_ff.bits + 4'h1;
					end else if (scl_fall && st_ff.bits == BYTE_BITS) begin
						case (st_ff.phase)
							PH_ADDR: begin
								ack = (st_ff.sh == {st_ff.addr, 1'b0});
							end
							PH_INDEX: begin
								ack        = 1'b1;
								nxt_st.idx = st_ff.sh;
							end
							PH_COUNT: begin
								ack         = 1'b1;
								nxt_st.left = st_ff.sh;
							end
							PH_DATA: begin
								ack  = (st_ff.left != 8'h00) & room;
								push = ack;
								if (ack) begin
									nxt_st.idx  = st_ff.idx + 8'h01;
									nxt_st.left = st_ff.left - 8'h01;
								end
							end
							default: ack = 1'b0;
						endcase
						if (ack) begin
							nxt_st.state  = D_ACK;
							nxt_st.sda_oe = 1'b1;
						end else begin
							nxt_st.state  = D_IGN;
						end
					end
				end
				D_ACK: begin
					if (scl_fall) begin
						nxt_st.sda_oe = 1'b0;
						nxt_st.bits   = 4'h0;
						nxt_st.state  = D_RX;
						case (st_ff.phase)
							PH_ADDR:  nxt_st.phase = PH_INDEX;
							PH_INDEX: nxt_st.phase = PH_COUNT;
							default:  nxt_st.phase = PH_DATA;
						endcase
					end
				end
				D_IDLE, D_IGN: nxt_st.sda_oe = 1'b0;
				default: nxt_st.state = D_IDLE;
			endcase
		end

		// Two-entry write buffer; head is always entry 0
		if (pop) begin
			nxt_st.fe0 = st_ff.fe1;
			nxt_st.fv  = {1'b0, st_ff.fv[1]};
			if (st_ff.fe0[15:11] == 5'h00 &&
			    REG_WR_MASK[st_ff.fe0[10:8]]) begin
				nxt_st.regs[st_ff.fe0[10:8]] = st_ff.fe0[7:0];
			end
		end
		if (push) begin
			if (!nxt_st.fv[0]) begin
				nxt_st.fe0   = {st_ff.idx, st_ff.sh};
				nxt_st.fv[0] = 1'b1;
			end else begin
				nxt_st.fe1   = {st_ff.idx, st_ff.sh};
				nxt_st.fv[1] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_ff       <= '0;
			st_ff.pd    <= 1'b1;
			// Bus wires idle high; a zero here would fake a stop edge
			st_ff.s1[SY_SCL] <= 1'b1;
			st_ff.s1[SY_SDA] <= 1'b1;
			st_ff.s2[SY_SCL] <= 1'b1;
			st_ff.s2[SY_SDA] <= 1'b1;
			st_ff.pv[SY_SCL] <= 1'b1;
			st_ff.pv[SY_SDA] <= 1'b1;
			st_ff.state <= D_IDLE;
			st_ff.phase <= PH_ADDR;
			for (int k = 0; k < NUM_REG; k++) begin
				st_ff.regs[k] <= REG_RST[k];
			end
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign smb.d_sda_o         = 1'b0;
	assign smb.d_sda_oe        = st_ff.sda_oe;
	assign diff_clock_output_o = st_ff.dclk;
	assign active_o            = st_ff.awake;
	assign wr_valid_o          = st_ff.fv[0];
	assign wr_index_o          = st_ff.fe0[15:8];
	assign wr_data_o           = st_ff.fe0[7:0];
endmodule : cfb_dev

// *** verilog/cfb_smb_host.sv ***
// Purpose: Bus host that issues one indexed block write per command.
// Assumes: Target does not stretch the bus clock.
// Notes:   Bus clock held low while waiting for the next data byte.
`timescale 1ns/100ps
module cfb_smb_host
	import cfb_pkg::*;
#(
	parameter int QTR_CYC = SCL_QTR_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	cfb_smb_if.host         smb,
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	input  wire logic [6:0] cmd_addr_i,
	input  wire logic [7:0] cmd_index_i,
	input  wire logic [7:0] cmd_count_i,
	input  wire logic       dat_valid_i,
	output logic            dat_ready_o,
	input  wire logic [7:0] dat_i,
	output logic            done_o,
	output logic            nack_o
);
	typedef struct packed {
		logic        sda_s1;
		logic        sda_s2;
		cfb_hstate_t state;
		cfb_phase_t  phase;
		logic [7:0]  qcnt;
		logic [1:0]  qtr;
		logic [3:0]  bits;
		logic [7:0]  sh;
		logic [7:0]  index;
		logic [7:0]  left;
		logic        scl_low;
		logic        sda_low;
		logic        ack_ok;
		logic        fail;
		logic        cmd_rdy;
		logic        dat_rdy;
		logic        done;
		logic        nack;
	} cfb_host_st_t;

	cfb_host_st_t st_ff;
	cfb_host_st_t nxt_st;
	logic         tick;

	// Quarter period rounded up keeps the bus clock under its limit
	assign tick = (st_ff.qcnt == 8'(QTR_CYC - 1));

	always_comb begin
		nxt_st        = st_ff;
		nxt_st.sda_s1 = smb.sda;
		nxt_st.sda_s2 = st_ff.sda_s1;
		nxt_st.done   = 1'b0;
		nxt_st.nack   = 1'b0;
		if (tick || st_ff.state == H_IDLE || st_ff.state == H_LOAD) begin
			nxt_st.qcnt = 8'h00;
		end else begin
			nxt_st.qcnt = st_ff.qcnt + 8'h01;
		end
		if (tick) begin
			nxt_st.qtr = st_ff.qtr + 2'h1;
		end
		case (st_ff.state)
			H_IDLE: begin
				nxt_st.cmd_rdy = 1'b1;
				if (st_ff.cmd_rdy && cmd_valid_i) begin
					nxt_st.cmd_rdy = 1'b0;
					nxt_st.state   = H_START;
					nxt_st.qtr     = 2'h0;
					nxt_st.sh      = {cmd_addr_i, 1'b0};
					nxt_st.index   = cmd_index_i;
					nxt_st.left    = cmd_count_i;
					nxt_st.phase   = PH_ADDR;
					nxt_st.bits    = 4'h0;
					nxt_st.fail    = 1'b0;
				end
			end
			H_START: begin
				if (tick) begin
					case (st_ff.qtr)
						2'h1:    nxt_st.sda_low = 1'b1;
						2'h2:    nxt_st.scl_low = 1'b1;
						2'h3:    nxt_st.state   = H_BIT;
						default: nxt_st.sda_low = 1'b0;
					endcase
				end
			end
			H_BIT: begin
				if (tick) begin
					case (st_ff.qtr)
						2'h0: nxt_st.sda_low = (st_ff.bits != BYTE_BITS) &
						                       ~st_ff.sh[7];
						2'h1: nxt_st.scl_low = 1'b0;
						2'h2: nxt_st.ack_ok  = ~st_ff.sda_s2;
						default: begin
							nxt_st.scl_low = 1'b1;
							if (st_ff.bits != BYTE_BITS) begin
								nxt_st.sh   = {st_ff.sh[6:0], 1'b0};
								nxt_st.bits = st_ff.bits + 4'h1;
							end else begin
								nxt_st.bits = 4'h0;
								if (!st_ff.ack_ok) begin
									nxt_st.fail  = 1'b1;
									nxt_st.state = H_STOP;
								end else begin
									case (st_ff.phase)
										PH_ADDR: begin
											nxt_st.sh    = st_ff.index;
											nxt_st.phase = PH_INDEX;
										end
										PH_INDEX: begin
											nxt_st.sh    = st_ff.left;
											nxt_st.phase = PH_COUNT;
										end
										default: begin
											nxt_st.phase = PH_DATA;
											if (st_ff.left == 8'h00) begin
												nxt_st.state = H_STOP;
											end else begin
												nxt_st.state   = H_LOAD;
												nxt_st.dat_rdy = 1'b1;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
			end
			H_LOAD: begin
				if (st_ff.dat_rdy && dat_valid_i) begin
					nxt_st.dat_rdy = 1'b0;
					nxt_st.sh      = dat_i;
					nxt_st.left    = st_ff.left - 8'h01;
					nxt_st.state   = H_BIT;
					nxt_st.qtr     = 2'h0;
				end
			end
			H_STOP: begin
				if (tick) begin
					case (st_ff.qtr)
						2'h0: nxt_st.sda_low = 1'b1;
						2'h1: nxt_st.scl_low = 1'b0;
						2'h2: nxt_st.sda_low = 1'b0;
						default: begin
							nxt_st.done  = 1'b1;
							nxt_st.nack  = st_ff.fail;
							nxt_st.state = H_IDLE;
						end
					endcase
				end
			end
			default: nxt_st.state = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_ff        <= '0;
			st_ff.sda_s1 <= 1'b1;
			st_ff.sda_s2 <= 1'b1;
			st_ff.state  <= H_IDLE;
			st_ff.phase  <= PH_ADDR;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign smb.h_scl_o  = 1'b0;
	assign smb.h_scl_oe = st_ff.scl_low;
	assign smb.h_sda_o  = 1'b0;
	assign smb.h_sda_oe = st_ff.sda_low;
	assign cmd_ready_o  = st_ff.cmd_rdy;
	assign dat_ready_o  = st_ff.dat_rdy;
	assign done_o       = st_ff.done;
	assign nack_o       = st_ff.nack;
endmodule : cfb_smb_host

// *** tb/cfb_sva.sv ***
// Purpose: Assertions on bus wires and device outputs.
// Assumes: One clock domain, reference clock near 320 ns.
// Notes:   Wake bound tracks the shortened wake limit.
`timescale 1ns/100ps
module cfb_sva
	import cfb_pkg::*;
#(
	parameter int WAKE_MAX_CYC = 40
) (
	input wire logic               clk_i,
	input wire logic               nrst_i,
	input wire logic               scl,
	input wire logic               d_sda_oe,
	input wire logic               power_good_powerdown_n_i,
	input wire logic [NUM_OUT-1:0] oe_n_i,
	input wire logic               wr_ready_i,
	input wire logic               active_o,
	input wire logic               wr_valid_o,
	input wire logic [7:0]         wr_index_o,
	input wire logic [7:0]         wr_data_o,
	input wire logic [NUM_OUT-1:0] diff_clock_output_o
);
	// Sync stages and one ref period of slack on top of the limit
	localparam int WAKE_HI = WAKE_MAX_CYC + 12;
	// Shortest legal bus clock period in system clocks, rounded down
	localparam int SCL_MIN = CLK_HZ / SMB_HZ_MAX;
	logic       scl_q_ff;
	logic [7:0] scl_per_ff;
	// Cycles since the last bus clock rise, saturating
	always_ff @(posedge clk_i) begin
		scl_q_ff <= scl;
		if (!nrst_i) begin
			scl_per_ff <= 8'hFF;
		end else if (scl && !scl_q_ff) begin
			scl_per_ff <= 8'h00;
		end else if (scl_per_ff != 8'hFF) begin
			scl_per_ff <= scl_per_ff + 8'h01;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	chk_ack_in_low: assert property (
		$rose(d_sda_oe) |-> !scl ##1 d_sda_oe [*7])
		else $error("ack not raised in scl low");
	chk_ack_one_bit: assert property (
		$rose(d_sda_oe) |-> ##[61:67] $fell(d_sda_oe))
		else $error("ack not one bit long");
	chk_ack_steady: assert property (
		scl && $past(scl) |-> $stable(d_sda_oe))
		else $error("sda moved while scl high");
	chk_pd_drop: assert property (
		$fell(power_good_powerdown_n_i) |-> ##[1:5] !active_o)
		else $error("power down not entered");
	chk_off_quiet: assert property (
		!active_o [*3] |-> diff_clock_output_o == '0)
		else $error("output runs while inactive");
	chk_wake_bound: assert property (
		$rose(power_good_powerdown_n_i) |-> ##[1:WAKE_HI] active_o)
		else $error("wake took too long");
	chk_oe_stop: assert property (
		$rose(oe_n_i[2]) |-> ##[1:30] !diff_clock_output_o[2] [*8])
		else $error("output 2 did not stop");
	chk_wr_hold: assert property (
		wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_index_o)
			&& $stable(wr_data_o))
		else $error("write entry changed while stalled");
	chk_scl_rate: assert property (
		$rose(scl) |-> scl_per_ff >= 8'(SCL_MIN))
		else $error("bus clock above its limit");
	cov_ack: cover property ($rose(d_sda_oe));
	cov_wake: cover property ($rose(active_o));
	cov_stall: cover property (wr_valid_o && !wr_ready_i);
endmodule : cfb_sva

// *** tb/cfb_tb.sv ***
// Purpose: Bench joining bus host and fanout device on one bus.
// Assumes: Reference clock 320 ns; wake limit cut to 40 cycles.
// Notes:   A stalled sink fills the write buffer to force a refusal.
`timescale 1ns/100ps
module cfb_tb
	import cfb_pkg::*;
();
	logic               clk_i = 1'b0;
	logic               nrst_i = 1'b0;
	logic               ref_clk = 1'b0;
	logic               ref_run = 1'b1;
	logic               pg_n = 1'b0;
	logic               wr_rdy = 1'b1;
	logic [1:0]         addr_sel = SEL_LOW;
	logic               cmd_vld = 1'b0;
	logic               dat_vld = 1'b0;
	logic [6:0]         cmd_adr = '0;
	logic [7:0]         cmd_idx = '0;
	logic [7:0]         cmd_cnt = '0;
	logic [7:0]         dat_d = '0;
	logic [NUM_OUT-1:0] oe_n = '0;
	logic               cmd_rdy, dat_rdy, done, nack, active, wr_vld;
	logic [7:0]         wr_idx, wr_dat;
	logic [NUM_OUT-1:0] dout;
	logic [7:0]         q_idx[$];
	logic [7:0]         q_dat[$];
	int                 mismatches = 0;
	int                 samples_checked = 0;
	int                 cyc = 0;

	cfb_smb_if smb_bus ();
	cfb_dev #(.WAKE_MAX_CYC(40)) u_cfb_dev (
		.clk_i(clk_i), .nrst_i(nrst_i), .smb(smb_bus),
		.diff_ref_clock_input_i(ref_clk), .power_good_powerdown_n_i(pg_n),
		.oe_n_i(oe_n), .bus_addr_select_pin_i(addr_sel), .wr_ready_i(wr_rdy),
		.diff_clock_output_o(dout), .active_o(active), .wr_valid_o(wr_vld),
		.wr_index_o(wr_idx), .wr_data_o(wr_dat));
	cfb_smb_host u_cfb_smb_host (
		.clk_i(clk_i), .nrst_i(nrst_i), .smb(smb_bus), .cmd_valid_i(cmd_vld),
		.cmd_ready_o(cmd_rdy), .cmd_addr_i(cmd_adr), .cmd_index_i(cmd_idx),
		.cmd_count_i(cmd_cnt), .dat_valid_i(dat_vld), .dat_ready_o(dat_rdy),
		.dat_i(dat_d), .done_o(done), .nack_o(nack));
	cfb_sva #(.WAKE_MAX_CYC(40)) u_cfb_sva (
		.clk_i(clk_i), .nrst_i(nrst_i), .scl(smb_bus.scl),
		.d_sda_oe(smb_bus.d_sda_oe), .power_good_powerdown_n_i(pg_n),
		.oe_n_i(oe_n), .wr_ready_i(wr_rdy), .active_o(active),
		.wr_valid_o(wr_vld), .wr_index_o(wr_idx), .wr_data_o(wr_dat),
		.diff_clock_output_o(dout));

	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// Odd offset keeps reference edges clear of system clock edges
	initial begin
		#7;
		forever #160 if (ref_run) ref_clk = ~ref_clk;
	end

	always @(posedge clk_i) begin
		cyc++;
		if (wr_vld === 1'b1 && wr_rdy === 1'b1) begin
			q_idx.push_back(wr_idx);
			q_dat.push_back(wr_dat);
		end
		if (cyc == 30000) begin
			mismatches++;
			summarize();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	// Marks every output that changed level inside the window
	task automatic toggles(input int n, output logic [7:0] s);
		logic [NUM_OUT-1:0] last;
		s = '0;
		last = dout;
		repeat (n) begin
			@(posedge clk_i);
			s[NUM_OUT-1:0] = s[NUM_OUT-1:0] | (dout ^ last);
			last = dout;
		end
	endtask : toggles

	task automatic xfer(input logic [6:0] a, input logic [7:0] n,
		input logic [7:0] x, input logic bad);
		int k;
		int w;
		k = 0;
		w = 0;
		cmd_vld <= 1'b1;
		cmd_adr <= a;
		cmd_idx <= n;
		cmd_cnt <= x;
		do @(posedge clk_i); while (cmd_rdy !== 1'b1);
		cmd_vld <= 1'b0;
		while (done !== 1'b1 && w < 4000) begin
			@(posedge clk_i);
			w++;
			if (dat_vld && dat_rdy === 1'b1) begin
				k++;
				dat_vld <= 1'b0;
			end else if (!dat_vld && dat_rdy === 1'b1) begin
				dat_vld <= 1'b1;
				dat_d <= 8'h5A + n + 8'(k);
			end
		end
		chk({6'h0, done, nack}, {6'h0, 1'b1, bad});
		if (!bad) chk(8'(k), x);
	endtask : xfer

	task automatic wake();
		int w;
		w = 0;
		pg_n <= 1'b1;
		while (active !== 1'b1 && w < 60) begin
			@(posedge clk_i);
			w++;
		end
		chk({7'h0, active}, 8'h01);
	endtask : wake

	task automatic t_start();
		logic [7:0] s;
		chk({7'h0, active}, 8'h00);
		toggles(24, s);
		chk(s, 8'h00);
		wake();
		toggles(32, s);
		chk(s, 8'h7F);
	endtask : t_start

	task automatic t_write();
		logic [7:0] s;
		xfer(ADDR_LOW, 8'h01, 8'h03, 1'b0);
		repeat (4) @(posedge clk_i);
		chk(8'(q_idx.size()), 8'h03);
		foreach (q_idx[k]) begin
			chk(q_idx[k], 8'h01 + 8'(k));
			chk(q_dat[k], 8'h5B + 8'(k));
		end
		q_idx.delete();
		q_dat.delete();
		// Byte 1 got bit 5 clear, so output 6 must have stopped
		toggles(32, s);
		chk(s, 8'h3F);
	endtask : t_write

	task automatic t_gate();
		logic [7:0] s;
		xfer(ADDR_LOW, 8'h00, 8'h01, 1'b0);
		toggles(32, s);
		chk(s, 8'h1C);
		oe_n[2] <= 1'b1;
		repeat (28) @(posedge clk_i);
		toggles(16, s);
		chk(s, 8'h18);
		oe_n[2] <= 1'b0;
		repeat (28) @(posedge clk_i);
		toggles(16, s);
		chk(s, 8'h1C);
		q_idx.delete();
		q_dat.delete();
	endtask : t_gate

	task automatic t_refuse();
		xfer(ADDR_MID, 8'h00, 8'h01, 1'b1);
		wr_rdy <= 1'b0;
		xfer(ADDR_LOW, 8'h10, 8'h04, 1'b1);
		chk(8'(q_idx.size()), 8'h00);
		wr_rdy <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(8'(q_idx.size()), 8'h02);
		chk(q_idx[1], 8'h11);
		q_idx.delete();
		q_dat.delete();
	endtask : t_refuse

	task automatic t_pdown();
		logic [7:0] s;
		pg_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({7'h0, active}, 8'h00);
		toggles(16, s);
		chk(s, 8'h00);
		xfer(ADDR_LOW, 8'h00, 8'h01, 1'b1);
		wake();
		toggles(32, s);
		chk(s, 8'h1C);
	endtask : t_pdown

	task automatic t_refstop();
		ref_run <= 1'b0;
		repeat (40) @(posedge clk_i);
		xfer(ADDR_LOW, 8'h07, 8'h01, 1'b1);
		ref_run <= 1'b1;
		repeat (40) @(posedge clk_i);
		xfer(ADDR_LOW, 8'h07, 8'h01, 1'b0);
		chk(q_idx[0], 8'h07);
	endtask : t_refstop

	// Mid-run reset re-latches the select on the next power-good only
	task automatic t_strap();
		q_idx.delete();
		q_dat.delete();
		nrst_i   <= 1'b0;
		pg_n     <= 1'b0;
		addr_sel <= SEL_MID;
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk({7'h0, active}, 8'h00);
		wake();
		addr_sel <= SEL_LOW;
		xfer(ADDR_LOW, 8'h00, 8'h01, 1'b1);
		xfer(ADDR_MID, 8'h02, 8'h01, 1'b0);
		chk(q_idx[0], 8'h02);
		chk(q_dat[0], 8'h5C);
	endtask : t_strap

	initial begin
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_start();
		t_write();
		t_gate();
		t_refuse();
		t_pdown();
		t_refstop();
		t_strap();
		summarize();
	end
endmodule : cfb_tb
